// ---- dv/fcn_flow_unit_asserts.sv ----
// checker of the program-flow unit, bound to its top module.
// assumes one clock domain and the synchronous reset of the unit.
`timescale 1ns/1ps
module fcn_flow_unit_asserts (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input wire fcn_pkg::fcn_op_s op_i,
    input wire logic [15:0] stack_pc_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic [15:0] next_pc_o,
    input wire logic [2:0] cycles_o,
    input wire logic taken_o,
    input wire logic [7:0] flags_o,
    input wire logic flags_we_o,
    input wire logic push_o,
    input wire logic [15:0] ret_addr_o,
    input wire logic pop_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // request taken at this edge, and its operation
    logic acc;
    fcn_pkg::fcn_op_e op;
    assign acc = op_valid_i && ready_o;
    assign op = op_i.op;

    // short branch offset is sign-extended from bit 6
    function automatic logic [15:0] tgt(logic [15:0] pc, logic [11:0] k);
        return pc + {{9{k[6]}}, k[6:0]} + 16'h0001;
    endfunction

    call_load_a: assert property (acc && op == fcn_pkg::FCN_INDIRECT_CALL |=>
        push_o && next_pc_o == $past(op_i.z_ptr) && ret_addr_o == $past(op_i.pc) + 16'h0001
        ##2 done_o) else $error("indirect call target or timing wrong");
    ret_len_a: assert property (acc && (op == fcn_pkg::FCN_SUBROUTINE_RETURN ||
        op == fcn_pkg::FCN_INTERRUPT_RETURN) |=> pop_o && cycles_o == 3'h4
        ##1 !done_o [*2] ##1 done_o) else $error("return length wrong");
    ret_pc_a: assert property (pop_o |-> ##2 next_pc_o == $past(stack_pc_i))
        else $error("return address not taken from stack");
    cmp_flags_a: assert property (acc && op == fcn_pkg::FCN_COMPARE_IMMEDIATE |=>
        done_o && flags_we_o && flags_o[1] == ($past(op_i.rd_val) == $past(op_i.imm))
        && flags_o[0] == ($past(op_i.rd_val) < $past(op_i.imm))) else $error("compare flags");
    flags_kept_a: assert property (acc && op != fcn_pkg::FCN_COMPARE_IMMEDIATE &&
        op != fcn_pkg::FCN_COMPARE_WITH_CARRY |=> flags_o == $past(op_i.status) && !flags_we_o)
        else $error("flags changed by a flow instruction");
    single_cyc_a: assert property (acc |=> done_o == (cycles_o == 3'h1))
        else $error("done does not match cycle count");
    status_br_a: assert property (acc && op == fcn_pkg::FCN_BRANCH_STATUS_BIT_SET |=>
        taken_o == $past(op_i.status[op_i.bit_sel]) && next_pc_o == (taken_o ?
        tgt($past(op_i.pc), $past(op_i.offset)) : $past(op_i.pc) + 16'h0001))
        else $error("status bit branch wrong");
    minus_br_a: assert property (acc && op == fcn_pkg::FCN_BRANCH_MINUS |=>
        taken_o == $past(op_i.status[2])) else $error("minus branch condition wrong");
    signed_br_a: assert property (acc && op == fcn_pkg::FCN_BRANCH_LESS_SIGNED |=>
        taken_o == ($past(op_i.status[2]) ^ $past(op_i.status[3])))
        else $error("signed branch condition wrong");
    skip_eq_a: assert property (acc && op == fcn_pkg::FCN_COMPARE_SKIP_EQUAL &&
        op_i.rd_val == op_i.rr_val |=> next_pc_o == $past(op_i.pc) +
        ($past(op_i.next_two_word) ? 16'h0003 : 16'h0002)) else $error("equal skip wrong");
    io_skip_a: assert property (acc && op == fcn_pkg::FCN_SKIP_IO_BIT_SET |=>
        taken_o == $past(op_i.io_val[op_i.bit_sel])) else $error("io bit skip wrong");

    // main scenarios: a return, back to back, a compare
    cover property (acc && op == fcn_pkg::FCN_SUBROUTINE_RETURN);
    cover property (done_o && acc);
    cover property (acc && op == fcn_pkg::FCN_COMPARE_IMMEDIATE ##1 flags_we_o);
endmodule

bind fcn_flow_unit fcn_flow_unit_asserts i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .stack_pc_i(stack_pc_i), .ready_o(ready_o),
    .done_o(done_o), .next_pc_o(next_pc_o), .cycles_o(cycles_o), .taken_o(taken_o),
    .flags_o(flags_o), .flags_we_o(flags_we_o), .push_o(push_o), .ret_addr_o(ret_addr_o),
    .pop_o(pop_o));

// ---- dv/fcn_flow_unit_test.sv ----
// self-checking bench of the program-flow unit: reset, then table of branches
// and skips, compares, offsets, calls and returns back to back, mid-run reset.
// assumes the stack model is the only far side.
`timescale 1ns/1ps
module fcn_flow_unit_test;
    typedef struct packed {
        fcn_pkg::fcn_op_e op;
        logic [7:0] st;
        logic [2:0] b;
        logic two;
        logic [2:0] cyc;
        logic [7:0] d;
    } fcn_row_s;

    // op, status, bit, two-word, cycles, pc advance (taken branch k+1 = 6)
    localparam fcn_row_s ROWS [22] = '{
        '{fcn_pkg::FCN_BRANCH_EQUAL, 8'h02, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_NOT_EQUAL, 8'h02, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_CARRY_SET, 8'h01, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_CARRY_CLEAR, 8'h01, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_SAME_OR_HIGHER, 8'h00, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_LOWER, 8'h00, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_MINUS, 8'h04, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_PLUS, 8'h04, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_GREATER_EQUAL_SIGNED, 8'h0C, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_LESS_SIGNED, 8'h08, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_LESS_SIGNED, 8'h0C, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_HALF_CARRY_SET, 8'h20, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_HALF_CARRY_CLEAR, 8'h20, 3'h0, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_BRANCH_TRANSFER_BIT_SET, 8'h40, 3'h0, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_STATUS_BIT_SET, 8'h80, 3'h7, 1'h0, 3'h2, 8'h06},
        '{fcn_pkg::FCN_BRANCH_STATUS_BIT_CLEAR, 8'h08, 3'h3, 1'h0, 3'h1, 8'h01},
        '{fcn_pkg::FCN_COMPARE_SKIP_EQUAL, 8'h00, 3'h0, 1'h1, 3'h3, 8'h03},
        '{fcn_pkg::FCN_SKIP_REG_BIT_CLEAR, 8'h00, 3'h0, 1'h0, 3'h2, 8'h02},
        '{fcn_pkg::FCN_SKIP_REG_BIT_SET, 8'h00, 3'h0, 1'h1, 3'h1, 8'h01},
        '{fcn_pkg::FCN_SKIP_IO_BIT_SET, 8'h00, 3'h1, 1'h1, 3'h3, 8'h03},
        '{fcn_pkg::FCN_SKIP_IO_BIT_CLEAR, 8'h00, 3'h2, 1'h0, 3'h2, 8'h02},
        '{fcn_pkg::FCN_NOP, 8'h00, 3'h0, 1'h0, 3'h1, 8'h01}
    };

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic op_valid_i = 1'b0;
    fcn_pkg::fcn_op_s op_i = '0;
    fcn_pkg::fcn_op_s base, o, r;
    logic [15:0] stack_pc, next_pc, ret_addr;
    logic ready, done, taken, flags_we, push, pop;
    logic [2:0] cycles;
    logic [7:0] flags;
    int n_fail = 0;
    int n_compared = 0;
    int tick = 0;

    fcn_flow_unit i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .stack_pc_i(stack_pc), .ready_o(ready), .done_o(done),
        .next_pc_o(next_pc), .cycles_o(cycles), .taken_o(taken), .flags_o(flags),
        .flags_we_o(flags_we), .push_o(push), .ret_addr_o(ret_addr), .pop_o(pop));
    fcn_stack_model i_stack (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .push_i(push),
        .ret_addr_i(ret_addr), .pop_i(pop), .stack_pc_o(stack_pc));

    // 20 MHz core clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // whole run is about a hundred cycles; a hang ends here
    always @(posedge clk_i) begin
        tick <= tick + 1;
        if (tick == 1000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // unit is idle on entry; keep leaves valid high with the next request
    task automatic send(input fcn_pkg::fcn_op_s a, input logic keep, input fcn_pkg::fcn_op_s nxt);
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i <= a;
        @(negedge clk_i);
        chk("ready", {15'h0, ready}, 16'h0001);
        @(posedge clk_i);
        if (keep) begin
            op_i <= nxt;
        end else begin
            op_valid_i <= 1'b0;
        end
    endtask

    // count busy cycles up to the done pulse
    task automatic finish(input logic [2:0] cyc);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (done !== 1'b1 && n < 8);
        chk("done cycle", 16'(n), {13'h0, cyc});
    endtask

    task automatic run(input fcn_pkg::fcn_op_s a, input logic [15:0] pc,
            input logic [2:0] cyc, input logic tk, input logic [7:0] fl);
        send(a, 1'b0, a);
        finish(cyc);
        chk("next pc", next_pc, pc);
        chk("cycles", {13'h0, cycles}, {13'h0, cyc});
        chk("taken", {15'h0, taken}, {15'h0, tk});
        chk("flags", {8'h00, flags}, {8'h00, fl});
    endtask

    initial begin
        base = '0;
        base.pc = 16'h0100;
        base.z_ptr = 16'h1234;
        base.rd_val = 8'h5A;
        base.rr_val = 8'h5A;
        base.io_val = 8'h5A;
        base.offset = 12'h005;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk("reset pc", next_pc, 16'h0000);
        chk("reset cycles", {13'h0, cycles}, 16'h0001);
        chk("reset flags", {8'h00, flags}, 16'h0000);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        $display("reset test done");
        foreach (ROWS[i]) begin
            o = base;
            o.op = ROWS[i].op;
            o.status = ROWS[i].st;
            o.bit_sel = ROWS[i].b;
            o.next_two_word = ROWS[i].two;
            run(o, 16'h0100 + {8'h00, ROWS[i].d}, ROWS[i].cyc, ROWS[i].d != 8'h01,
                ROWS[i].st);
        end
        $display("table test done");
        // borrow sets C and N; equality sets Z; chained compare subtracts carry
        o = base;
        o.op = fcn_pkg::FCN_COMPARE_IMMEDIATE;
        o.rd_val = 8'h10;
        o.imm = 8'h20;
        run(o, 16'h0101, 3'h1, 1'b0, 8'h05);
        chk("flag write", {15'h0, flags_we}, 16'h0001);
        o.rd_val = 8'h33;
        o.imm = 8'h33;
        o.status = 8'h01;
        run(o, 16'h0101, 3'h1, 1'b0, 8'h02);
        o.op = fcn_pkg::FCN_COMPARE_WITH_CARRY;
        o.rr_val = 8'h33;
        run(o, 16'h0101, 3'h1, 1'b0, 8'h25);
        o = base;
        o.op = fcn_pkg::FCN_COMPARE_SKIP_EQUAL;
        o.rr_val = 8'h5B;
        run(o, 16'h0101, 3'h1, 1'b0, 8'h00);
        // negative offset, upper offset bits ignored by short branches
        o = base;
        o.op = fcn_pkg::FCN_BRANCH_EQUAL;
        o.status = 8'h02;
        o.offset = 12'hF7E;
        run(o, 16'h00FF, 3'h2, 1'b1, 8'h02);
        $display("compare and offset test done");
        // call with the return waiting: refused while busy, taken at done
        o = base;
        o.op = fcn_pkg::FCN_INDIRECT_CALL;
        o.status = 8'hA5;
        r = o;
        r.op = fcn_pkg::FCN_SUBROUTINE_RETURN;
        r.pc = 16'h1234;
        send(o, 1'b1, r);
        finish(3'h3);
        chk("call pc", next_pc, 16'h1234);
        chk("call flags", {8'h00, flags}, 16'h00A5);
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        finish(3'h4);
        chk("return pc", next_pc, 16'h0101);
        o.op = fcn_pkg::FCN_RELATIVE_CALL;
        o.pc = 16'h0200;
        o.offset = 12'hFFE;
        send(o, 1'b0, o);
        finish(3'h3);
        chk("relative call pc", next_pc, 16'h01FF);
        r.op = fcn_pkg::FCN_INTERRUPT_RETURN;
        send(r, 1'b0, r);
        finish(3'h4);
        chk("interrupt return pc", next_pc, 16'h0201);
        chk("return flags", {8'h00, flags}, 16'h00A5);
        $display("call and return test done");
        // reset over two edges in the middle of a return abandons it
        send(r, 1'b0, r);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk("mid reset strobes", {11'h0, ready, done, push, pop, flags_we}, 16'h0010);
        chk("mid reset pc", next_pc, 16'h0000);
        chk("mid reset state", {4'h0, cycles, taken, flags}, 16'h0200);
        o = base;
        o.op = fcn_pkg::FCN_BRANCH_EQUAL;
        o.status = 8'h02;
        run(o, 16'h0106, 3'h2, 1'b1, 8'h02);
        $display("mid-run reset test done");
        print_verdict();
    end
endmodule

// ---- dv/fcn_stack_model.sv ----
// stack model at the far side of the program-flow unit.
// assumes push and pop never fall in one cycle; depth of eight words.
`timescale 1ns/1ps
module fcn_stack_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic push_i,
    input wire logic [15:0] ret_addr_i,
    input wire logic pop_i,
    output logic [15:0] stack_pc_o = 16'hA5C3
);
    logic [15:0] mem [8];
    logic [2:0] sp_reg = 3'h0;

    // popped word shown one cycle only; it toggles after, so a late
    // capture cannot see a stale but plausible address
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sp_reg <= 3'h0;
            stack_pc_o <= ~stack_pc_o;
        end else if (push_i) begin
            mem[sp_reg] <= ret_addr_i;
            sp_reg <= sp_reg + 3'h1;
            stack_pc_o <= ~stack_pc_o;
        end else if (pop_i) begin
            stack_pc_o <= mem[sp_reg - 3'h1];
            sp_reg <= sp_reg - 3'h1;
        end else begin
            stack_pc_o <= ~stack_pc_o;
        end
    end
endmodule

// ---- hw/fcn_flow_unit.sv ----
// program-flow unit: next program counter, cycle count and flag update
// for calls, returns, compare-and-skip, bit-test skips and branches.
// assumes the decoder presents operands already read, and that the stack
// returns the popped address one cycle after the pop pulse.
`timescale 1ns/1ps

// Notes on behaviour
// - indirect call saves return address, loads PC from Z, flags kept.
// - both returns reload PC from stack in 4 cycles, flags kept.
// - equal registers skip next instruction, PC plus 2 or 3, 1/2/3 cycles.
// - immediate compare subtracts without store, sets Z N V C H, 1 cycle.
// - register bit skip when bit matches clear or set sense, 1 to 3 cycles.
// - I/O bit skip on 0 for clear, 1 for set, 1 to 3 cycles.
// - status bit branch to PC+k+1 on set or clear sense, 1 or 2 cycles.
// - minus branches on N one, plus on N zero, no flag change.
// - carry set and lower on C one, clear and same-or-higher on C zero.
// - signed branches use N xor V: zero for greater-equal, one for less.
// - half-carry branches on H one or zero, one or two cycles.
// - transfer bit branch taken when T is one, PC+k+1.
module fcn_flow_unit (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input fcn_pkg::fcn_op_s op_i,
    input wire logic [15:0] stack_pc_i,
    output logic ready_o,
    output logic done_o,
    output logic [15:0] next_pc_o,
    output logic [2:0] cycles_o,
    output logic taken_o,
    output logic [7:0] flags_o,
    output logic flags_we_o,
    output logic push_o,
    output logic [15:0] ret_addr_o,
    output logic pop_o
);

    fcn_pkg::fcn_state_e state_reg;
    logic [2:0] step_reg;
    logic [2:0] len_reg;
    logic [15:0] next_pc_reg;
    logic taken_reg;
    logic [7:0] flags_reg;
    logic we_reg;
    logic push_reg;
    logic pop_reg;
    logic [15:0] ret_addr_reg;

    logic accept;
    logic busy;
    logic last_step;

    // decode results
    logic cond;
    logic is_branch;
    logic is_skip;
    logic [2:0] dec_cycles;
    logic [15:0] dec_target;
    logic [7:0] dec_flags;
    logic dec_we;
    logic dec_push;
    logic dec_pop;

    // arithmetic for the compares
    logic [7:0] sub_opnd;
    logic [7:0] sub_cin;
    logic [7:0] sub_res;
    logic flag_h;
    logic flag_v;
    logic flag_n;
    logic flag_z;
    logic flag_c;
    logic zero_chain;

    // addresses
    logic [15:0] seq_pc;
    logic [15:0] br_ext;
    logic [15:0] call_ext;
    logic [15:0] br_target;
    logic [15:0] call_target;
    logic reg_bit;
    logic io_bit;
    logic [7:0] st;

    // handshake: a new op may be taken while idle or in the last cycle
    assign busy = (state_reg == fcn_pkg::FCN_BUSY);
    assign last_step = busy && (step_reg == len_reg - fcn_pkg::FCN_STEP_ONE);
    assign ready_o = !busy || last_step;
    assign accept = op_valid_i && ready_o;
    assign done_o = last_step;

    // pulses toward the stack in the first busy cycle
    assign push_o = busy && push_reg && (step_reg == fcn_pkg::FCN_STEP_FIRST);
    assign pop_o = busy && pop_reg && (step_reg == fcn_pkg::FCN_STEP_FIRST);
    assign flags_we_o = last_step && we_reg;

    assign next_pc_o = next_pc_reg;
    assign cycles_o = len_reg;
    assign taken_o = taken_reg;
    assign flags_o = flags_reg;
    assign ret_addr_o = ret_addr_reg;

    // address arithmetic, wraps at the top of the program space
    assign st = op_i.status;
    assign seq_pc = op_i.pc + fcn_pkg::FCN_WORD_STEP;
    assign br_ext = {{9{op_i.offset[fcn_pkg::FCN_BR_OFS_MSB]}},
                     op_i.offset[fcn_pkg::FCN_BR_OFS_MSB:0]};
    assign call_ext = {{4{op_i.offset[fcn_pkg::FCN_CALL_OFS_MSB]}}, op_i.offset};
    assign br_target = op_i.pc + br_ext + fcn_pkg::FCN_WORD_STEP;
    assign call_target = op_i.pc + call_ext + fcn_pkg::FCN_WORD_STEP;
    assign reg_bit = op_i.rr_val[op_i.bit_sel];
    assign io_bit = op_i.io_val[op_i.bit_sel];

    assign sub_opnd = (op_i.op == fcn_pkg::FCN_COMPARE_IMMEDIATE) ? op_i.imm : op_i.rr_val;
    assign sub_cin = (op_i.op == fcn_pkg::FCN_COMPARE_WITH_CARRY) ?
                     {7'h00, st[fcn_pkg::FCN_FLAG_C]} : 8'h00;
    assign sub_res = op_i.rd_val - sub_opnd - sub_cin;

    assign flag_h = (~op_i.rd_val[3] & sub_opnd[3]) | (sub_opnd[3] & sub_res[3])
                    | (sub_res[3] & ~op_i.rd_val[3]);
    assign flag_v = (op_i.rd_val[7] & ~sub_opnd[7] & ~sub_res[7])
                    | (~op_i.rd_val[7] & sub_opnd[7] & sub_res[7]);
    assign flag_n = sub_res[7];
    assign flag_c = (~op_i.rd_val[7] & sub_opnd[7]) | (sub_opnd[7] & sub_res[7])
                    | (sub_res[7] & ~op_i.rd_val[7]);
    // with carry, Z only stays set, so multi-byte compares chain
    assign zero_chain = (op_i.op == fcn_pkg::FCN_COMPARE_WITH_CARRY) ?
                        st[fcn_pkg::FCN_FLAG_Z] : 1'b1;
    assign flag_z = (sub_res == 8'h00) && zero_chain;

    // decode of condition, target, cycles and side effects
    always_comb begin
        cond = 1'b0;
        is_branch = 1'b0;
        is_skip = 1'b0;
        dec_cycles = fcn_pkg::FCN_CYC_BASE;
        dec_target = seq_pc;
        dec_flags = st;
        dec_we = 1'b0;
        dec_push = 1'b0;
        dec_pop = 1'b0;
        case (op_i.op)
            fcn_pkg::FCN_RELATIVE_CALL: begin
                dec_target = call_target;
                dec_cycles = fcn_pkg::FCN_CYC_CALL;
                dec_push = 1'b1;
            end
            fcn_pkg::FCN_INDIRECT_CALL: begin
                dec_target = op_i.z_ptr;
                dec_cycles = fcn_pkg::FCN_CYC_CALL;
                dec_push = 1'b1;
            end
            fcn_pkg::FCN_SUBROUTINE_RETURN, fcn_pkg::FCN_INTERRUPT_RETURN: begin
                dec_cycles = fcn_pkg::FCN_CYC_RET;
                dec_pop = 1'b1;
            end
            fcn_pkg::FCN_COMPARE_SKIP_EQUAL: begin
                is_skip = 1'b1;
                cond = (op_i.rd_val == op_i.rr_val);
            end
            fcn_pkg::FCN_COMPARE_WITH_CARRY, fcn_pkg::FCN_COMPARE_IMMEDIATE: begin
                dec_we = 1'b1;
                dec_flags[fcn_pkg::FCN_FLAG_C] = flag_c;
                dec_flags[fcn_pkg::FCN_FLAG_Z] = flag_z;
                dec_flags[fcn_pkg::FCN_FLAG_N] = flag_n;
                dec_flags[fcn_pkg::FCN_FLAG_V] = flag_v;
                dec_flags[fcn_pkg::FCN_FLAG_H] = flag_h;
            end
            fcn_pkg::FCN_SKIP_REG_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond = !reg_bit;
            end
            fcn_pkg::FCN_SKIP_REG_BIT_SET: begin
                is_skip = 1'b1;
                cond = reg_bit;
            end
            fcn_pkg::FCN_SKIP_IO_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond = !io_bit;
            end
            fcn_pkg::FCN_SKIP_IO_BIT_SET: begin
                is_skip = 1'b1;
                cond = io_bit;
            end
            fcn_pkg::FCN_BRANCH_STATUS_BIT_SET: begin
                is_branch = 1'b1;
                cond = st[op_i.bit_sel];
            end
            fcn_pkg::FCN_BRANCH_STATUS_BIT_CLEAR: begin
                is_branch = 1'b1;
                cond = !st[op_i.bit_sel];
            end
            fcn_pkg::FCN_BRANCH_EQUAL: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_Z];
            end
            fcn_pkg::FCN_BRANCH_NOT_EQUAL: begin
                is_branch = 1'b1;
                cond = !st[fcn_pkg::FCN_FLAG_Z];
            end
            fcn_pkg::FCN_BRANCH_CARRY_SET, fcn_pkg::FCN_BRANCH_LOWER: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_C];
            end
            fcn_pkg::FCN_BRANCH_CARRY_CLEAR, fcn_pkg::FCN_BRANCH_SAME_OR_HIGHER: begin
                is_branch = 1'b1;
                cond = !st[fcn_pkg::FCN_FLAG_C];
            end
            fcn_pkg::FCN_BRANCH_MINUS: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_N];
            end
            fcn_pkg::FCN_BRANCH_PLUS: begin
                is_branch = 1'b1;
                cond = !st[fcn_pkg::FCN_FLAG_N];
            end
            fcn_pkg::FCN_BRANCH_GREATER_EQUAL_SIGNED: begin
                is_branch = 1'b1;
                cond = !(st[fcn_pkg::FCN_FLAG_N] ^ st[fcn_pkg::FCN_FLAG_V]);
            end
            fcn_pkg::FCN_BRANCH_LESS_SIGNED: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_N] ^ st[fcn_pkg::FCN_FLAG_V];
            end
            fcn_pkg::FCN_BRANCH_HALF_CARRY_SET: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_H];
            end
            fcn_pkg::FCN_BRANCH_HALF_CARRY_CLEAR: begin
                is_branch = 1'b1;
                cond = !st[fcn_pkg::FCN_FLAG_H];
            end
            fcn_pkg::FCN_BRANCH_TRANSFER_BIT_SET: begin
                is_branch = 1'b1;
                cond = st[fcn_pkg::FCN_FLAG_T];
            end
            default: begin
                dec_cycles = fcn_pkg::FCN_CYC_BASE;
            end
        endcase
        if (is_skip && cond) begin
            dec_target = op_i.pc + (op_i.next_two_word ?
                         fcn_pkg::FCN_SKIP_LONG : fcn_pkg::FCN_SKIP_SHORT);
            dec_cycles = op_i.next_two_word ?
                         fcn_pkg::FCN_CYC_SKIP_LONG : fcn_pkg::FCN_CYC_SKIP_SHORT;
        end
        if (is_branch && cond) begin
            dec_target = br_target;
            dec_cycles = fcn_pkg::FCN_CYC_TAKEN;
        end
    end

    // sequencer: one busy cycle per instruction cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= fcn_pkg::FCN_IDLE;
        end else if (accept) begin
            state_reg <= fcn_pkg::FCN_BUSY;
        end else if (last_step) begin
            state_reg <= fcn_pkg::FCN_IDLE;
        end
    end

    // cycle counter within the instruction
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            step_reg <= fcn_pkg::FCN_STEP_FIRST;
            len_reg <= fcn_pkg::FCN_CYC_BASE;
        end else if (accept) begin
            step_reg <= fcn_pkg::FCN_STEP_FIRST;
            len_reg <= dec_cycles;
        end else if (busy) begin
            step_reg <= step_reg + fcn_pkg::FCN_STEP_ONE;
        end
    end

    // next program counter; a return overwrites it from the stack later
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            next_pc_reg <= fcn_pkg::FCN_PC_RESET;
            taken_reg <= 1'b0;
        end else if (accept) begin
            next_pc_reg <= dec_target;
            taken_reg <= (is_branch || is_skip) && cond;
        end else if (busy && pop_reg && step_reg == fcn_pkg::FCN_STACK_STEP) begin
            next_pc_reg <= stack_pc_i;
        end
    end

    // flags: only compares write, others keep the status register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flags_reg <= fcn_pkg::FCN_FLAGS_RESET;
            we_reg <= 1'b0;
        end else if (accept) begin
            flags_reg <= dec_flags;
            we_reg <= dec_we;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            ret_addr_reg <= fcn_pkg::FCN_PC_RESET;
        end else if (accept) begin
            push_reg <= dec_push;
            pop_reg <= dec_pop;
            ret_addr_reg <= seq_pc;
        end
    end

endmodule

// ---- hw/fcn_pkg.sv ----
// package of the program-flow unit: operation codes, operand carrier,
// flag positions, cycle counts and reset values.
// assumes the core decoder fills one fcn_op_s per instruction.
package fcn_pkg;

    // address width of program counter, Z pointer and stack words
    localparam int FCN_ADDR_W = 16;

    // status register bit positions
    localparam int FCN_FLAG_C = 0;
    localparam int FCN_FLAG_Z = 1;
    localparam int FCN_FLAG_N = 2;
    localparam int FCN_FLAG_V = 3;
    localparam int FCN_FLAG_S = 4;
    localparam int FCN_FLAG_H = 5;
    localparam int FCN_FLAG_T = 6;
    localparam int FCN_FLAG_I = 7;

    // compares touch C, Z, N, V and H only
    localparam logic [7:0] FCN_CMP_MASK = 8'h2F;
    localparam logic [7:0] FCN_FLAGS_RESET = 8'h00;
    localparam logic [7:0] FCN_MASK_NONE = 8'h00;

    // cycle counts of each case
    localparam logic [2:0] FCN_CYC_BASE = 3'h1;
    localparam logic [2:0] FCN_CYC_TAKEN = 3'h2;
    localparam logic [2:0] FCN_CYC_SKIP_SHORT = 3'h2;
    localparam logic [2:0] FCN_CYC_SKIP_LONG = 3'h3;
    localparam logic [2:0] FCN_CYC_CALL = 3'h3;
    localparam logic [2:0] FCN_CYC_RET = 3'h4;
    localparam logic [2:0] FCN_STEP_FIRST = 3'h0;
    localparam logic [2:0] FCN_STEP_ONE = 3'h1;
    // busy step in which the popped return address is taken
    localparam logic [2:0] FCN_STACK_STEP = 3'h1;

    // program counter increments and reset value
    localparam logic [15:0] FCN_PC_RESET = 16'h0000;
    localparam logic [15:0] FCN_WORD_STEP = 16'h0001;
    localparam logic [15:0] FCN_SKIP_SHORT = 16'h0002;
    localparam logic [15:0] FCN_SKIP_LONG = 16'h0003;

    // offset field layout: short branch offset is the low 7 bits
    localparam int FCN_BR_OFS_MSB = 6;
    localparam int FCN_CALL_OFS_MSB = 11;

    typedef enum logic [4:0] {
        FCN_NOP,
        FCN_RELATIVE_CALL,
        FCN_INDIRECT_CALL,
        FCN_SUBROUTINE_RETURN,
        FCN_INTERRUPT_RETURN,
        FCN_COMPARE_SKIP_EQUAL,
        FCN_COMPARE_WITH_CARRY,
        FCN_COMPARE_IMMEDIATE,
        FCN_SKIP_REG_BIT_CLEAR,
        FCN_SKIP_REG_BIT_SET,
        FCN_SKIP_IO_BIT_CLEAR,
        FCN_SKIP_IO_BIT_SET,
        FCN_BRANCH_STATUS_BIT_SET,
        FCN_BRANCH_STATUS_BIT_CLEAR,
        FCN_BRANCH_EQUAL,
        FCN_BRANCH_NOT_EQUAL,
        FCN_BRANCH_CARRY_SET,
        FCN_BRANCH_CARRY_CLEAR,
        FCN_BRANCH_SAME_OR_HIGHER,
        FCN_BRANCH_LOWER,
        FCN_BRANCH_MINUS,
        FCN_BRANCH_PLUS,
        FCN_BRANCH_GREATER_EQUAL_SIGNED,
        FCN_BRANCH_LESS_SIGNED,
        FCN_BRANCH_HALF_CARRY_SET,
        FCN_BRANCH_HALF_CARRY_CLEAR,
        FCN_BRANCH_TRANSFER_BIT_SET
    } fcn_op_e;

    typedef enum {
        FCN_IDLE,
        FCN_BUSY
    } fcn_state_e;

    // one instruction with all operands already fetched
    typedef struct packed {
        fcn_op_e op;
        logic [15:0] pc;
        logic [15:0] z_ptr;
        logic [7:0] status;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] imm;
        logic [7:0] io_val;
        logic [2:0] bit_sel;
        logic [11:0] offset;
        logic next_two_word;
    } fcn_op_s;

endpackage
